// File: pkg/adc_readout_pkg.sv
package adc_readout_pkg;
  // ---------------------------------------------------------------------------
  // Controller register map (Wishbone byte addresses).
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_OFS    = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS  = 8'h04;
  localparam logic [7:0] REG_RESULT0_OFS = 8'h10;
  localparam logic [7:0] REG_RESULT1_OFS = 8'h14;
  localparam logic [7:0] REG_RESULT2_OFS = 8'h18;
  localparam logic [7:0] REG_RESULT3_OFS = 8'h1C;

  // ---------------------------------------------------------------------------
  // Control register fields.
  // ---------------------------------------------------------------------------
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_MODE_LSB    = 1;
  localparam int CTRL_HBEN_BIT    = 3;
  localparam int CTRL_SPLIT_BIT   = 4;
  localparam int CTRL_DUAL_BIT    = 5;
  localparam int CTRL_FRAME_BIT   = 6;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Status register fields.
  // ---------------------------------------------------------------------------
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_DONE_BIT    = 1;
  localparam int STAT_MARKER_BIT  = 2;
  localparam int STAT_ORDER_BIT   = 3;
  localparam int STAT_ADC_BUSY_BIT = 4;

  // ---------------------------------------------------------------------------
  // Readout geometry and timing.
  // ---------------------------------------------------------------------------
  localparam int NUM_CHANNELS     = 4;
  localparam int RESULT_BITS      = 16;
  localparam int CLK_PERIOD_NS    = 20;
  localparam int STROBE_LOW_NS    = 60;
  localparam int STROBE_HIGH_NS   = 60;
  localparam int STROBE_LOW_CYC   = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC  = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC    = 2;
  localparam int CNT_BITS         = 4;

  // ---------------------------------------------------------------------------
  // Readout modes as pin straps.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_BYTE,
    MODE_SERIAL
  } read_mode_t;
endpackage

// File: hdl/result_store.sv
module result_store
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // Write port and registered read port.
  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule

// File: hdl/adc_readout_host.sv
// Contract
// - Interface select low picks parallel mode.
// - Tied strobes: first fall gives channel 1.
// - Shared bus: drive select, read separately.
// - Both select pins high pick byte mode.
// - Byte order input: high sends upper first.
// - Byte mode: eight read pulses, byte each.
// - Serial: interface high, byte select low.
// - Sixteen serial clocks per channel, MSB first.
// - Host may frame each word separately.
// - 64 clocks single line, 32 dual.
// - Raise select before busy falls; the sequencer ignores busy.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
module adc_readout_host
  import adc_readout_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             cs_n_out,
  output logic             rd_n_out,
  output logic             sclk_out,
  output logic             interface_select_out,
  output logic             byte_select_out,
  output logic             byte_order_select_out,
  input  wire logic [15:0] parallel_data_bus_in,
  input  wire logic        serial_out_a_in,
  input  wire logic        serial_out_b_in,
  input  wire logic        first_channel_marker_in,
  input  wire logic        busy_in
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_GAP,
    ST_DONE
  } state_t;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [15:0] db_s1_r;
  logic [15:0] db_s2_r;
  logic [2:0]  pin_s1_r;
  logic [2:0]  pin_s2_r;
  logic        busy_d_r;

  // Two flops on every device output before any logic looks at it.
  always_ff @(posedge clk_sys_in) begin
    db_s1_r  <= parallel_data_bus_in;
    db_s2_r  <= db_s1_r;
    pin_s1_r <= {busy_in, serial_out_b_in, serial_out_a_in};
    pin_s2_r <= pin_s1_r;
    busy_d_r <= pin_s2_r[2];
  end

  wire logic sda_w     = pin_s2_r[0];
  wire logic sdb_w     = pin_s2_r[1];
  wire logic busy_w    = pin_s2_r[2];
  wire logic busy_fall = busy_d_r & ~busy_w;

  logic        mark_s1_r;
  logic        mark_s2_r;

  // Marker synchroniser.
  always_ff @(posedge clk_sys_in) begin
    mark_s1_r <= first_channel_marker_in;
    mark_s2_r <= mark_s1_r;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [6:0]  ctrl_r;
  logic        done_r;
  logic        order_err_r;
  state_t      state_r;

  wire logic [1:0] mode_w  = ctrl_r[CTRL_MODE_LSB +: 2];
  wire logic       hben_w  = ctrl_r[CTRL_HBEN_BIT];
  wire logic       split_w = ctrl_r[CTRL_SPLIT_BIT];
  wire logic       dual_w  = ctrl_r[CTRL_DUAL_BIT];
  wire logic       frame_w = ctrl_r[CTRL_FRAME_BIT];
  wire logic       is_par  = (mode_w == 2'(MODE_PARALLEL));
  wire logic       is_byte = (mode_w == 2'(MODE_BYTE));
  wire logic       is_ser  = ~is_par & ~is_byte;

  // Mode straps held on the select pins.
  assign interface_select_out  = ~is_par;
  assign byte_select_out       = is_byte;
  assign byte_order_select_out = hben_w;

  // Bus decode.
  wire logic wb_req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire logic hit_ctrl  = (wb_adr_in == REG_CTRL_OFS);
  wire logic hit_stat  = (wb_adr_in == REG_STATUS_OFS);
  wire logic hit_res   = (wb_adr_in[7:4] == REG_RESULT0_OFS[7:4]) && (wb_adr_in[1:0] == 2'h0);
  wire logic start_wr  = wb_req & wb_we_in & hit_ctrl & wb_sel_in[0] & wb_dat_in[CTRL_START_BIT];
  wire logic run_w     = (state_r != ST_IDLE) && (state_r != ST_DONE);
  wire logic start_go  = start_wr & ~run_w;

  // ---------------------------------------------------------------------------
  // Readout sequencer
  // ---------------------------------------------------------------------------
  logic [CNT_BITS-1:0] tmr_r;
  logic [5:0]          step_r;
  logic [15:0]         sh_a_r;
  logic [15:0]         sh_b_r;
  logic [7:0]          byte_hold_r;
  logic [15:0]         cap_r;
  logic                cs_n_r;
  logic                rd_n_r;
  logic                sclk_r;

  // Transfers per set: 4 words, 8 bytes, or 64/32 serial bits.
  wire logic [5:0] last_step = is_par  ? 6'h03 :
                               is_byte ? 6'h07 :
                               dual_w  ? 6'h1F : 6'h3F;
  wire logic [CNT_BITS-1:0] low_len  = is_ser ? CNT_BITS'(SCLK_HALF_CYC) : CNT_BITS'(STROBE_LOW_CYC);
  wire logic [CNT_BITS-1:0] high_len = is_ser ? CNT_BITS'(SCLK_HALF_CYC) : CNT_BITS'(STROBE_HIGH_CYC);
  wire logic tmr_end   = (tmr_r == '0);
  wire logic last_w    = (step_r == last_step);
  wire logic word_end  = (step_r[3:0] == 4'hF);
  // Serial: rearm select after each 16-bit word when framing per word.
  wire logic frame_gap = is_ser & frame_w & word_end;

  // Sequencer state register.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      tmr_r   <= '0;
      step_r  <= '0;
    end else begin
      case (state_r)
        ST_IDLE, ST_DONE: begin
          if (start_go) begin
            state_r <= ST_GAP;
            tmr_r   <= high_len;
            step_r  <= '0;
          end
        end
        ST_GAP: begin
          tmr_r <= tmr_r - CNT_BITS'(1);
          if (tmr_end) begin
            state_r <= ST_LOW;
            tmr_r   <= low_len;
          end
        end
        ST_LOW: begin
          tmr_r <= tmr_r - CNT_BITS'(1);
          if (tmr_end) begin
            state_r <= ST_HIGH;
            tmr_r   <= high_len;
          end
        end
        default: begin
          tmr_r <= tmr_r - CNT_BITS'(1);
          if (tmr_end) begin
            tmr_r <= low_len;
            if (last_w) begin
              state_r <= ST_DONE;
            end else begin
              step_r  <= step_r + 6'h01;
              state_r <= frame_gap ? ST_GAP : ST_LOW;
            end
          end
        end
      endcase
    end
  end

  // Strobe pins follow the state; select stays low across the whole set unless parallel or byte strobes are tied, or serial words are framed.
  // Select falls at the last gap cycle, one cycle ahead of the first serial clock
  // fall, so the first bit is already on the line when it is sampled.
  wire logic cs_low_w = (state_r == ST_LOW) || (state_r == ST_HIGH) ||
                        ((state_r == ST_GAP) && tmr_end);
  wire logic rd_low_w = ~is_ser & (split_w ? (state_r == ST_LOW) : 1'b0);

  // Pin drive from flops.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      sclk_r <= 1'b1;
    end else begin
      // Tied strobes pulse select with read; separate keeps select low.
      cs_n_r <= (~is_ser & ~split_w) ? ~(state_r == ST_LOW) : ~cs_low_w;
      rd_n_r <= split_w ? ~rd_low_w : ~(~is_ser & (state_r == ST_LOW));
      // Serial clock falls in ST_LOW; data shifts on that fall.
      sclk_r <= ~(is_ser & (state_r == ST_LOW));
    end
  end

  assign cs_n_out = cs_n_r;
  assign rd_n_out = rd_n_r;
  assign sclk_out = sclk_r;

  // ---------------------------------------------------------------------------
  // Data capture
  // ---------------------------------------------------------------------------
  // Sample at the end of each low phase, after bus settles.
  wire logic sample_w = (state_r == ST_LOW) & tmr_end;
  wire logic mark_exp = is_ser ? ((step_r[5:4] == 2'h0) | (dual_w & (step_r[4] == 1'b0)))
                               : (is_par ? (step_r == 6'h00) : (step_r[5:1] == 5'h00));
  logic [1:0]  wr_ch;
  logic [15:0] wr_word;
  logic        wr_en;
  logic [15:0] st_rd;

  // Serial shifters and byte pairing.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sh_a_r      <= '0;
      sh_b_r      <= '0;
      byte_hold_r <= '0;
      cap_r       <= '0;
      order_err_r <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      if (sample_w) begin
        sh_a_r <= {sh_a_r[14:0], sda_w};
        sh_b_r <= {sh_b_r[14:0], sdb_w};
        // Tied strobes release the bus in the high phase, so the word is kept here.
        cap_r  <= db_s2_r;
        // The first byte of each pair waits here for its partner.
        if (!step_r[0]) begin
          byte_hold_r <= db_s2_r[7:0];
        end
        // Marker must match channel 1 (and channel 3 on B).
        if (mark_s2_r != mark_exp) begin
          order_err_r <= 1'b1;
        end
      end
      if (start_go) begin
        done_r      <= 1'b0;
        order_err_r <= 1'b0;
      end else if ((state_r == ST_HIGH) & tmr_end & last_w) begin
        done_r <= 1'b1;
      end
    end
  end

  // Result word and channel of each completed transfer.
  always_comb begin
    wr_en   = 1'b0;
    wr_ch   = 2'h0;
    wr_word = cap_r;
    if ((state_r == ST_HIGH) & tmr_end) begin
      if (is_par) begin
        wr_en   = 1'b1;
        wr_ch   = step_r[1:0];
        wr_word = cap_r;
      end else if (is_byte) begin
        wr_en   = step_r[0];
        wr_ch   = step_r[2:1];
        wr_word = hben_w ? {byte_hold_r, cap_r[7:0]} : {cap_r[7:0], byte_hold_r};
      end else begin
        wr_en   = word_end;
        wr_ch   = step_r[5:4];
        wr_word = sh_a_r;
      end
    end
  end

  logic [1:0] rd_ch;
  assign rd_ch = wb_adr_in[3:2];

  result_store #(
    .WIDTH(RESULT_BITS),
    .DEPTH(NUM_CHANNELS)
  ) u_store (
    .clk_sys_in (clk_sys_in),
    .wr_en_in   (wr_en),
    .wr_addr_in (wr_ch),
    .wr_data_in (wr_word),
    .rd_addr_in (rd_ch),
    .rd_data_out(st_rd)
  );

  // Dual lines: B's first two words are channels 3 and 4.
  logic [15:0] dual_b_r [2];
  always_ff @(posedge clk_sys_in) begin
    if (wr_en & is_ser & dual_w) begin
      dual_b_r[wr_ch[0]] <= sh_b_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  logic        rd_phase_r;
  wire logic [31:0] stat_w = {27'h0, busy_w, order_err_r, mark_s2_r, done_r, run_w};
  wire logic use_b = dual_w & is_ser & rd_ch[1];
  wire logic [15:0] res_w = use_b ? dual_b_r[rd_ch[0]] : st_rd;

  // Control writes and two-cycle read answer (store read is registered).
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctrl_r     <= CTRL_RESET_VAL[6:0];
      wb_ack_out <= 1'b0;
      rd_phase_r <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      wb_ack_out <= 1'b0;
      if (wb_req & wb_we_in) begin
        wb_ack_out <= 1'b1;
        // Config is frozen during a readout so pins stay stable.
        if (hit_ctrl & wb_sel_in[0] & ~run_w) begin
          ctrl_r <= {wb_dat_in[6:1], 1'b0};
        end
      end else if (wb_req & ~rd_phase_r) begin
        rd_phase_r <= 1'b1;
      end else if (wb_req) begin
        rd_phase_r <= 1'b0;
        wb_ack_out <= 1'b1;
        if (hit_ctrl) begin
          wb_dat_out <= {25'h0, ctrl_r};
        end else if (hit_stat) begin
          wb_dat_out <= stat_w;
        end else if (hit_res) begin
          wb_dat_out <= {16'h0, res_w};
        end else begin
          wb_dat_out <= '0;
        end
      end
    end
  end

  // Busy fall marks fresh results; the host reads any time, stale while busy.
  logic fresh_r;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      fresh_r <= 1'b0;
    end else if (busy_fall) begin
      fresh_r <= 1'b1;
    end else if (start_go) begin
      fresh_r <= 1'b0;
    end
  end
endmodule

// File: sim/adc_dev_model.sv
// -----------------------------------------------------------------------------
// Behavioural converter readout port, answering the host's strobes.
// -----------------------------------------------------------------------------
module adc_dev_model (
  input  wire logic        cs_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        sclk_in,
  input  wire logic        interface_select_in,
  input  wire logic        byte_select_in,
  input  wire logic        byte_order_select_in,
  input  wire logic        busy_in,
  output logic      [15:0] parallel_data_bus_out,
  output logic             serial_out_a_out,
  output logic             serial_out_b_out,
  output logic             first_channel_marker_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] res_r [4] = '{16'h8001, 16'h4C3A, 16'hF00F, 16'h2B96};
  logic [5:0]  ptr_r     = 6'h00;
  logic [2:0]  cur_r     = 3'h0;
  logic [18:0] hold_r    = 19'h2A5C3;

  // Word, byte and bit selection from the readout pointers.
  wire         ser_mode  = interface_select_in & ~byte_select_in;
  wire         byte_mode = interface_select_in & byte_select_in;
  wire  [1:0]  word_idx  = byte_mode ? cur_r[2:1] : cur_r[1:0];
  wire  [15:0] word      = res_r[word_idx];
  wire  [7:0]  half      = (cur_r[0] ^ ~byte_order_select_in) ? word[7:0] : word[15:8];
  wire  [3:0]  bit_idx   = ~ptr_r[3:0];
  wire  [1:0]  ch_a      = ptr_r[5:4];
  wire  [1:0]  ch_b      = ptr_r[5:4] + 2'd2;
  wire         mark      = ser_mode ? (ch_a == 2'd0) : (word_idx == 2'd0);
  wire  [18:0] drive     = {mark, res_r[ch_a][bit_idx], res_r[ch_b][bit_idx],
                            byte_mode ? {~half, half} : word};

  // Released pins show the inverse of their last level, never a kind value.
  assign {first_channel_marker_out, serial_out_a_out, serial_out_b_out, parallel_data_bus_out} =
    cs_n_in ? ~hold_r : drive;

  // New results load and the pointer restarts only when a conversion ends.
  always @(negedge busy_in) begin
    foreach (res_r[k]) res_r[k] = res_r[k] * 16'h0005 + 16'h3C71;
    ptr_r = 6'h00;
  end

  // Each read strobe fall hands out the next word or byte.
  always @(negedge rd_n_in) if (!ser_mode) begin
    cur_r = ptr_r[2:0];
    ptr_r = ptr_r + 6'h01;
  end

  // The serial clock shifts only inside a frame.
  always @(negedge sclk_in) if (ser_mode && !cs_n_in) ptr_r = ptr_r + 6'h01;

  // Remember the driven levels when the frame closes.
  always @(posedge cs_n_in) hold_r = drive;
endmodule

// File: sim/adc_readout_host_chk.sv
// -----------------------------------------------------------------------------
// Port checker for the readout host.
// -----------------------------------------------------------------------------
module adc_readout_host_chk (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic wb_ack_out,
  input wire logic cs_n_out,
  input wire logic rd_n_out,
  input wire logic sclk_out,
  input wire logic interface_select_out,
  input wire logic byte_select_out,
  input wire logic byte_order_select_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q_r;
  logic [3:0] falls_r;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  // Counts serial clock falls modulo one word.
  always_ff @(posedge clk_sys_in) begin
    sclk_q_r <= sclk_out;
    if (sys_rst_in) falls_r <= 4'h0;
    else if (sclk_q_r && !sclk_out) falls_r <= falls_r + 4'h1;
  end

  property p_sclk_idle; cs_n_out |-> sclk_out; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock moved outside a frame");
  property p_rd_framed; !rd_n_out |-> !cs_n_out; endproperty
  a_rd_framed: assert property (p_rd_framed) else $error("read strobe without chip select");
  property p_par_no_sclk; !interface_select_out |-> sclk_out; endproperty
  a_par_no_sclk: assert property (p_par_no_sclk) else $error("serial clock in parallel mode");
  property p_ser_no_rd; interface_select_out && !byte_select_out |-> rd_n_out; endproperty
  a_ser_no_rd: assert property (p_ser_no_rd) else $error("read strobe in serial mode");
  property p_sel_combo; byte_select_out |-> interface_select_out; endproperty
  a_sel_combo: assert property (p_sel_combo) else $error("invalid mode pin pair");
  property p_pins_hold;
    !cs_n_out && $past(!cs_n_out) |-> $stable({interface_select_out, byte_select_out, byte_order_select_out});
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("mode pins changed in a frame");
  property p_rd_low; $fell(rd_n_out) |-> !rd_n_out [*3]; endproperty
  a_rd_low: assert property (p_rd_low) else $error("read strobe low too short");
  property p_rd_high; $rose(rd_n_out) |-> rd_n_out [*3]; endproperty
  a_rd_high: assert property (p_rd_high) else $error("read strobe high too short");
  property p_sclk_low; $fell(sclk_out) |-> !sclk_out [*2]; endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("serial clock low too short");
  property p_word_whole; $rose(cs_n_out) && interface_select_out && !byte_select_out |-> falls_r == 4'h0; endproperty
  a_word_whole: assert property (p_word_whole) else $error("serial frame not whole words");
  property p_wr_ack; $rose(wb_stb_in) && wb_we_in |=> wb_ack_out; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged next cycle");

  // Main readout flavours seen.
  c_par: cover property ($rose(cs_n_out) && !interface_select_out);
  c_byte: cover property ($rose(cs_n_out) && byte_select_out);
  c_ser: cover property ($rose(cs_n_out) && interface_select_out && !byte_select_out);
endmodule

// File: sim/adc_readout_host_tb_top.sv
// -----------------------------------------------------------------------------
// Register level bench for the readout host.
// -----------------------------------------------------------------------------
module adc_readout_host_tb_top;
  import adc_readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic        busy = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q, rdat;
  logic        ack, cs_n, rd_n, sclk, ifs, bsel, bord, sa, sb, mark;
  logic [15:0] bus;
  logic [15:0] exp_r [4];
  int          bad_count  = 0;
  int          n_compared = 0;
  int          n;
  logic [31:0] cfg [7] = '{32'h01, 32'h11, 32'h0B, 32'h03, 32'h05, 32'h25, 32'h45};

  // Clock generation.
  always #10 clk = ~clk;

  adc_readout_host adc_readout_host_i (
    .clk_sys_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .sclk_out(sclk), .interface_select_out(ifs),
    .byte_select_out(bsel), .byte_order_select_out(bord), .parallel_data_bus_in(bus),
    .serial_out_a_in(sa), .serial_out_b_in(sb), .first_channel_marker_in(mark), .busy_in(busy));

  adc_dev_model adc_dev_model_i (
    .cs_n_in(cs_n), .rd_n_in(rd_n), .sclk_in(sclk), .interface_select_in(ifs), .byte_select_in(bsel),
    .byte_order_select_in(bord), .busy_in(busy), .parallel_data_bus_out(bus), .serial_out_a_out(sa),
    .serial_out_b_out(sb), .first_channel_marker_out(mark));

  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compares one value against its expectation.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One classic Wishbone cycle; read data lands in q.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (ack !== 1'b1) begin
      bad_count++;
      final_report();
    end
    @(posedge clk);
  endtask

  // Main sequence: reset, register checks, then each readout flavour.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk("ctrl_reset", q, CTRL_RESET_VAL);
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped", q, 32'h0);
    foreach (cfg[i]) begin
      busy <= 1'b1;
      repeat (3) @(posedge clk);
      busy <= (i == 3);
      repeat (3) @(posedge clk);
      foreach (exp_r[k]) exp_r[k] = adc_dev_model_i.res_r[k];
      wb(1'b1, REG_CTRL_OFS, cfg[i]);
      chk("mode_pins", 32'({ifs, bsel, bord}), 32'({cfg[i][2:1] != 2'd0, cfg[i][2:1] == 2'd1, cfg[i][3]}));
      wb(1'b1, REG_CTRL_OFS, 32'h05);
      n = 0;
      do begin
        wb(1'b0, REG_STATUS_OFS, 32'h0);
        n++;
      end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 400);
      chk("finished", 32'(q[STAT_BUSY_BIT]), 32'h0);
      if (n == 400) final_report();
      chk("marker_ok", 32'(q[STAT_ORDER_BIT]), 32'h0);
      wb(1'b0, REG_CTRL_OFS, 32'h0);
      chk("ctrl_kept", q, cfg[i] & 32'hFFFF_FFFE);
      for (int k = 0; k < NUM_CHANNELS; k++) begin
        wb(1'b0, REG_RESULT0_OFS + 8'(4 * k), 32'h0);
        chk("result", q, 32'(exp_r[k]));
      end
    end
    final_report();
  end
endmodule

bind adc_readout_host adc_readout_host_chk adc_readout_host_chk_i (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_ack_out(wb_ack_out), .cs_n_out(cs_n_out), .rd_n_out(rd_n_out), .sclk_out(sclk_out),
  .interface_select_out(interface_select_out), .byte_select_out(byte_select_out),
  .byte_order_select_out(byte_order_select_out));
